//--- core/bal_pkg.sv
/*
 * Shared types and constants for the byte arithmetic and logic unit.
 * Assumes a single core clock and a decoder that presents one operation
 * per request together with its operands.
 */
`default_nettype none

package bal_pkg;

   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      BAL_OP_ADD = 4'h0,
      BAL_OP_ADC = 4'h1,
      BAL_OP_WADD = 4'h2, // word_immediate_add_op
      BAL_OP_SUB = 4'h3,
      BAL_OP_SUBK = 4'h4, // constant_subtract_op
      BAL_OP_SBR = 4'h5, // register_borrow_subtract_op
      BAL_OP_SBK = 4'h6, // constant_borrow_subtract_op
      BAL_OP_WSUB = 4'h7, // word_immediate_subtract_op
      BAL_OP_AND = 4'h8,
      BAL_OP_ANDK = 4'h9, // constant_bitwise_and_op
      BAL_OP_OR = 4'hA,
      BAL_OP_ORK = 4'hB, // constant_bitwise_or_op
      BAL_OP_XOR = 4'hC // register_bitwise_xor_op
   } bal_op_t;

   // ----------------------------------------------------------------
   // Flag layout and widths
   // ----------------------------------------------------------------
   localparam int BAL_W = 8;
   localparam int BAL_MSB = 7;
   localparam int BAL_NIB = 4;
   localparam logic [7:0] BAL_ZERO = 8'h00;
   localparam logic [15:0] BAL_WZERO = 16'h0000;

   typedef struct packed {
      logic h; // Half carry or borrow out of bit 3; zero on word results.
      logic v; // Two's complement overflow.
      logic n; // Result bit 7, or bit 15 of a word result.
      logic c; // Carry or borrow.
      logic z; // Result is zero.
   } bal_flags_t;

   localparam bal_flags_t BAL_FLAGS_RST = '0;

   // Request from the decoder.
   typedef struct packed {
      logic valid;
      bal_op_t op;
      logic [7:0] dst; // Destination, or low byte of a word pair.
      logic [7:0] dstHi; // High byte of a word pair.
      logic [7:0] src; // source_register or immediate constant.
   } bal_req_t;

   // Result toward the register file.
   typedef struct packed {
      logic valid;
      logic wordWrite;
      logic [7:0] resLo;
      logic [7:0] resHi;
      bal_flags_t flags;
   } bal_res_t;

   // Word-operation phases, one-hot.
   typedef enum logic [1:0] {
      BAL_ST_IDLE = 2'b01,
      BAL_ST_HIGH = 2'b10
   } bal_state_t;

endpackage

`default_nettype wire

//--- core/bal_unit.sv
/*
 * Byte arithmetic and logic unit: byte add and subtract with and without
 * carry, word immediate add and subtract on a pair, AND, OR and XOR.
 * Assumes the decoder holds a request stable and waits while busy is high.
 */
`default_nettype none

module bal_unit
   import bal_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Decoder request and incoming flags.
   input wire bal_req_t req,
   input wire bal_flags_t flagsIn,
   // Result and handshake.
   output bal_res_t res,
   output logic busy
);

   typedef struct packed {
      bal_state_t st;
      logic [7:0] lo;
      logic carry;
      logic sub;
      logic [7:0] hiIn;
      bal_res_t out;
   } bal_reg_t;

   bal_reg_t s_q;
   bal_reg_t s_d;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Byte results go out one edge after the request; word work is split
   // into two byte passes so the adder stays eight bits wide.
   always_comb begin
      logic [8:0] sum;
      logic [4:0] nib;
      logic [7:0] b;
      logic [7:0] r;
      logic [15:0] w;
      logic cin;
      logic isSub;
      logic arith;
      sum = '0;
      nib = '0;
      b = req.src;
      r = BAL_ZERO;
      w = BAL_WZERO;
      cin = 1'b0;
      isSub = 1'b0;
      arith = 1'b1;
      s_d = s_q;
      s_d.out.valid = 1'b0;
      s_d.out.wordWrite = 1'b0;
      unique case (s_q.st)
         BAL_ST_IDLE: begin
            if (req.valid) begin
               unique case (req.op)
                  BAL_OP_ADC: cin = flagsIn.c;
                  BAL_OP_SUB, BAL_OP_SUBK: isSub = 1'b1;
                  BAL_OP_SBR, BAL_OP_SBK: begin
                     isSub = 1'b1;
                     cin = flagsIn.c;
                  end
                  BAL_OP_WSUB: isSub = 1'b1;
                  default: ;
               endcase
               // Subtraction is addition of the complement with inverted
               // carry in and out.
               if (isSub) begin
                  sum = {1'b0, req.dst} + {1'b0, ~b} + {8'h00, ~cin};
                  nib = {1'b0, req.dst[BAL_NIB-1:0]} + {1'b0, ~b[BAL_NIB-1:0]}
                        + {4'h0, ~cin};
               end else begin
                  sum = {1'b0, req.dst} + {1'b0, b} + {8'h00, cin};
                  nib = {1'b0, req.dst[BAL_NIB-1:0]} + {1'b0, b[BAL_NIB-1:0]}
                        + {4'h0, cin};
               end
               r = sum[BAL_W-1:0];
               unique case (req.op)
                  BAL_OP_AND, BAL_OP_ANDK: begin
                     r = req.dst & req.src;
                     arith = 1'b0;
                  end
                  BAL_OP_OR, BAL_OP_ORK: begin
                     r = req.dst | req.src;
                     arith = 1'b0;
                  end
                  BAL_OP_XOR: begin
                     r = req.dst ^ req.src;
                     arith = 1'b0;
                  end
                  default: ;
               endcase
               s_d.out.flags.z = (r == BAL_ZERO);
               s_d.out.flags.n = r[BAL_MSB];
               if (arith) begin
                  s_d.out.flags.c = sum[BAL_W] ^ isSub;
                  s_d.out.flags.h = nib[BAL_NIB] ^ isSub;
                  s_d.out.flags.v = (req.dst[BAL_MSB] == (b[BAL_MSB]
                     ^ isSub)) && (r[BAL_MSB] != req.dst[BAL_MSB]);
               end else begin
                  s_d.out.flags.c = flagsIn.c;
                  s_d.out.flags.h = flagsIn.h;
                  s_d.out.flags.v = 1'b0;
               end
               s_d.out.resLo = r;
               s_d.out.resHi = req.dstHi;
               // word work waits for the high pass.
               if (req.op == BAL_OP_WADD || req.op == BAL_OP_WSUB) begin
                  s_d.st = BAL_ST_HIGH;
                  s_d.lo = r;
                  s_d.carry = sum[BAL_W];
                  s_d.sub = isSub;
                  s_d.hiIn = req.dstHi;
               end else begin
                  s_d.out.valid = 1'b1;
               end
            end
         end
         BAL_ST_HIGH: begin
            // high byte of the pair add.
            // high byte of the pair subtract.
            // The low pass leaves no-borrow in carry, so the high byte
            // adds all ones plus that carry to take the borrow off.
            if (s_q.sub) begin
               sum = {1'b0, s_q.hiIn} + 9'h0FF + {8'h00, s_q.carry};
            end else begin
               sum = {1'b0, s_q.hiIn} + {8'h00, s_q.carry};
            end
            r = sum[BAL_W-1:0];
            w = {r, s_q.lo};
            s_d.out.resLo = s_q.lo;
            s_d.out.resHi = r;
            s_d.out.flags.z = (w == BAL_WZERO);
            s_d.out.flags.n = r[BAL_MSB];
            s_d.out.flags.c = sum[BAL_W] ^ s_q.sub;
            s_d.out.flags.v = s_q.sub ? (s_q.hiIn[BAL_MSB] & ~r[BAL_MSB])
                                      : (~s_q.hiIn[BAL_MSB] & r[BAL_MSB]);
            s_d.out.flags.h = 1'b0;
            s_d.out.valid = 1'b1;
            s_d.out.wordWrite = 1'b1;
            s_d.st = BAL_ST_IDLE;
         end
         default: s_d.st = BAL_ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: BAL_ST_IDLE, lo: BAL_ZERO, carry: 1'b0, sub: 1'b0,
                  hiIn: BAL_ZERO, out: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign res = s_q.out;
   // The high pass reads only stored state; the request is ignored while busy.
   assign busy = (s_q.st == BAL_ST_HIGH);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   byte_one_cycle_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op != BAL_OP_WADD
          && req.op != BAL_OP_WSUB) |=> res.valid && !res.wordWrite)
      else $error("Byte operation did not finish in one cycle.");

   word_two_cycle_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && (req.op == BAL_OP_WADD
          || req.op == BAL_OP_WSUB)) |=> busy ##1 (res.valid
          && res.wordWrite))
      else $error("Word operation did not finish in two cycles.");

   add_result_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_ADC) |=> res.resLo ==
          8'($past(req.dst) + $past(req.src) + {7'h00, $past(flagsIn.c)}))
      else $error("Add with carry gave a wrong sum.");

   word_add_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_WADD) |=> ##1
          {res.resHi, res.resLo} == 16'({$past(req.dstHi, 2),
          $past(req.dst, 2)} + {8'h00, $past(req.src, 2)}))
      else $error("Word add gave a wrong pair.");

   word_sub_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_WSUB) |=> ##1
          {res.resHi, res.resLo} == 16'({$past(req.dstHi, 2),
          $past(req.dst, 2)} - {8'h00, $past(req.src, 2)}))
      else $error("Word subtract gave a wrong pair.");

   sub_result_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_SUBK) |=>
          res.resLo == 8'($past(req.dst) - $past(req.src)))
      else $error("Subtract gave a wrong difference.");

   borrow_sub_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_SBR) |=> res.resLo ==
          8'($past(req.dst) - $past(req.src) - {7'h00, $past(flagsIn.c)}))
      else $error("Borrow subtract gave a wrong difference.");

   borrow_const_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_SBK) |=> res.resLo ==
          8'($past(req.dst) - $past(req.src) - {7'h00, $past(flagsIn.c)}))
      else $error("Constant borrow subtract gave a wrong difference.");

   and_result_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && (req.op == BAL_OP_AND
          || req.op == BAL_OP_ANDK)) |=> !res.flags.v
          && res.resLo == ($past(req.dst) & $past(req.src)))
      else $error("AND result or overflow flag is wrong.");

   or_result_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && (req.op == BAL_OP_OR
          || req.op == BAL_OP_ORK)) |=> !res.flags.v
          && res.resLo == ($past(req.dst) | $past(req.src)))
      else $error("OR result or overflow flag is wrong.");

   logic_flags_a:
      assert property (@(posedge mclk) disable iff (!rst_b)
         (req.valid && !busy && req.op == BAL_OP_XOR) |=> !res.flags.v
          && res.flags.z == (res.resLo == 8'h00)
          && res.resLo == ($past(req.dst) ^ $past(req.src)))
      else $error("Exclusive OR result or flags are wrong.");

endmodule

`default_nettype wire

//--- test/bal_rf_model.sv
/*
 * Register file model standing behind the unit's result port.
 * Assumes results arrive as single-cycle valid pulses on mclk.
 */
`default_nettype none

module bal_rf_model
   import bal_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_b,
   // Result from the unit and stored state.
   input wire bal_res_t res,
   output var logic [7:0] rfLo,
   output var logic [7:0] rfHi,
   output var bal_flags_t rfFlags
);
   timeunit 1ns;
   timeprecision 1ps;

   // Write back on each pulse; the high byte only on word results.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rfLo <= 8'h00;
         rfHi <= 8'h00;
         rfFlags <= BAL_FLAGS_RST;
      end else if (res.valid) begin
         rfLo <= res.resLo;
         rfFlags <= res.flags;
         if (res.wordWrite) begin
            rfHi <= res.resHi;
         end
      end
   end
endmodule

`default_nettype wire

//--- test/testbench.sv
/*
 * Self-checking bench for the byte arithmetic and logic unit.
 * Assumes the register file model beside it and a 100 MHz core clock.
 */
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
 $display("mismatch at %0t: got %h want %h", $time, (g), (e)); end end

module testbench
   import bal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'h0;
   logic rst_b = 1'h0;
   bal_req_t req = '0;
   bal_flags_t flagsIn = '0;
   bal_res_t res;
   logic busy;
   logic [7:0] rfLo, rfHi;
   bal_flags_t rfFlags;
   int error_cnt = 0;
   int checked = 0;

   bal_unit bal_unit_i (.mclk(mclk), .rst_b(rst_b), .req(req),
      .flagsIn(flagsIn), .res(res), .busy(busy));
   bal_rf_model bal_rf_model_i (.mclk(mclk), .rst_b(rst_b), .res(res),
      .rfLo(rfLo), .rfHi(rfHi), .rfFlags(rfFlags));

   // Clock of 10 ns period.
   always #5 mclk = ~mclk;

   // Expected {word result, flags}; computed independently of the design.
   function automatic logic [20:0] expv(bal_op_t o, logic [7:0] d, h, s,
      bal_flags_t f);
      logic sb, ci, w, lg;
      logic [16:0] a, b, r;
      logic [4:0] nb;
      int m;
      bal_flags_t x;
      w = (o == BAL_OP_WADD) || (o == BAL_OP_WSUB);
      sb = o inside {BAL_OP_SUB, BAL_OP_SUBK, BAL_OP_SBR, BAL_OP_SBK,
         BAL_OP_WSUB};
      ci = (o inside {BAL_OP_ADC, BAL_OP_SBR, BAL_OP_SBK}) & f.c;
      lg = o >= BAL_OP_AND;
      a = w ? {1'h0, h, d} : {9'h000, d};
      b = {9'h000, s};
      r = sb ? a - b - ci : a + b + ci;
      nb = sb ? {1'h0, d[3:0]} - s[3:0] - ci : {1'h0, d[3:0]} + s[3:0] + ci;
      m = w ? 15 : 7;
      case (o)
         BAL_OP_AND, BAL_OP_ANDK: r = {9'h000, d & s};
         BAL_OP_OR, BAL_OP_ORK: r = {9'h000, d | s};
         BAL_OP_XOR: r = {9'h000, d ^ s};
         default: ;
      endcase
      x.z = w ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
      x.n = r[m];
      x.c = lg ? f.c : r[w ? 16 : 8];
      x.h = lg ? f.h : (!w & nb[4]);
      x.v = !lg & (a[m] ^ r[m]) & (sb ? a[m] ^ b[m] : !(a[m] ^ b[m]));
      return {r[15:0], x};
   endfunction

   // One operation; with hold set, a second request is offered while busy.
   task automatic op(bal_op_t o, logic [7:0] d, h, s, bal_flags_t f,
      logic hold);
      logic [20:0] e;
      int n;
      e = expv(o, d, h, s, f);
      n = 1;
      @(posedge mclk);
      req <= '{1'h1, o, d, h, s};
      flagsIn <= f;
      @(posedge mclk);
      if (hold) req.op <= BAL_OP_XOR;
      else req.valid <= 1'h0;
      #1;
      while (res.valid !== 1'h1 && n < 4) begin
         @(posedge mclk);
         req.valid <= 1'h0;
         #1;
         n++;
      end
      `CHK(n, (o == BAL_OP_WADD || o == BAL_OP_WSUB) ? 2 : 1)
      `CHK(res.resLo, e[12:5])
      `CHK(res.flags, e[4:0])
      @(posedge mclk);
      #1;
      `CHK({res.valid, busy, rfLo, rfFlags}, {2'h0, e[12:0]})
      if (n == 2) `CHK(rfHi, e[20:13])
   endtask

   // Reset values, checked during and after a reset in mid-run.
   task automatic t_reset();
      @(posedge mclk);
      rst_b <= 1'h0;
      #1;
      `CHK({res, busy}, 24'h000000)
      repeat (2) @(posedge mclk);
      rst_b <= 1'h1;
      @(posedge mclk);
      #1;
      `CHK({res, busy}, 24'h000000)
   endtask

   task automatic t_add();
      op(BAL_OP_ADD, 8'h7F, 8'h00, 8'h01, '0, 1'h0);
      op(BAL_OP_ADD, 8'hF8, 8'h00, 8'h08, '0, 1'h0);
      op(BAL_OP_ADC, 8'hFE, 8'h00, 8'h01, 5'h02, 1'h0);
      op(BAL_OP_ADC, 8'h0E, 8'h00, 8'h01, 5'h00, 1'h0);
   endtask

   task automatic t_word();
      op(BAL_OP_WADD, 8'hFF, 8'hFF, 8'h01, '0, 1'h1);
      op(BAL_OP_WADD, 8'hC0, 8'h7F, 8'h3F, 5'h02, 1'h0);
      op(BAL_OP_WSUB, 8'h00, 8'h00, 8'h01, '0, 1'h1);
      op(BAL_OP_WSUB, 8'h05, 8'h80, 8'h06, 5'h02, 1'h0);
   endtask

   task automatic t_sub();
      op(BAL_OP_SUB, 8'h80, 8'h00, 8'h01, 5'h02, 1'h0);
      op(BAL_OP_SUBK, 8'h10, 8'h00, 8'h10, 5'h02, 1'h0);
      op(BAL_OP_SBR, 8'h10, 8'h00, 8'h0F, 5'h02, 1'h0);
      op(BAL_OP_SBR, 8'h00, 8'h00, 8'h00, 5'h02, 1'h0);
      op(BAL_OP_SBK, 8'h40, 8'h00, 8'h20, 5'h02, 1'h0);
      op(BAL_OP_SBK, 8'h01, 8'h00, 8'h01, 5'h02, 1'h0);
   endtask

   task automatic t_logic();
      op(BAL_OP_AND, 8'hF0, 8'h00, 8'h0F, 5'h1A, 1'h0);
      op(BAL_OP_ANDK, 8'hC3, 8'h00, 8'h81, 5'h00, 1'h0);
      op(BAL_OP_OR, 8'h80, 8'h00, 8'h01, 5'h08, 1'h0);
      op(BAL_OP_ORK, 8'h00, 8'h00, 8'h00, 5'h12, 1'h0);
      op(BAL_OP_XOR, 8'hA5, 8'h00, 8'hA5, 5'h0B, 1'h0);
   endtask

   // Verdict and end of the run.
   task automatic end_sim();
      $display("errors %0d, comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about seventy cycles.
   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'h1;
      t_add();
      t_word();
      t_reset();
      t_sub();
      t_logic();
      end_sim();
   end
endmodule

`default_nettype wire
